// ---- src/fwil_params.svh ----
// Constants of the flash write inhibit lock
`ifndef FWIL_PARAMS_SVH
`define FWIL_PARAMS_SVH
`define FWIL_LOCK1_ADDR   24'h801030
`define FWIL_LOCK2_ADDR   24'h801034
`define FWIL_LOCK1_VALUE  16'h6d63
`define FWIL_LOCK2_VALUE  16'h6870
`define FWIL_CTRL_WR_BIT  15
`define FWIL_CTRL_ERR_BIT 13
`define FWIL_ERASED_WORD  16'hffff
`endif

// ---- src/fwil_pkg.sv ----
// Types of the flash write inhibit lock
package fwil_pkg;
  typedef enum logic [1:0] {
    FWIL_SRC_PORT,
    FWIL_SRC_ENH,
    FWIL_SRC_SELF,
    FWIL_SRC_DEBUG
  } fwil_src_t;

  typedef enum logic [1:0] {
    FWIL_OP_WORD,
    FWIL_OP_ROW,
    FWIL_OP_ERASE,
    FWIL_OP_CHECKED
  } fwil_op_t;

  typedef enum logic [1:0] {
    FWIL_ST_RESET,
    FWIL_ST_LOAD,
    FWIL_ST_RUN
  } fwil_state_t;

  typedef struct packed {
    fwil_state_t state;
    logic        active;
    logic        wr_bit;
    logic        err_bit;
    logic        grant;
    logic        resp_valid;
    logic        resp_pass;
    logic        prod_ok;
  } fwil_regs_t;
endpackage

// ---- src/fwil_lock.sv ----
// Flash write inhibit lock: arbitrates nonvolatile writes against the lock
`include "fwil_params.svh"
module fwil_lock (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // Stored lower 16 bits of both lock locations, read at reset
  input  wire logic [15:0]       lock1_word,
  input  wire logic [15:0]       lock2_word,
  // Nonvolatile operation request
  input  wire logic              req_valid,
  input  wire fwil_pkg::fwil_src_t req_src,
  input  wire fwil_pkg::fwil_op_t  req_op,
  input  wire logic [23:0]       req_addr,
  input  wire logic [23:0]       req_data,
  input  wire logic [15:0]       target_word,
  input  wire logic              ctrl_wr_set,
  input  wire logic              prod_mode_req,
  output logic                   grant,
  output logic                   resp_valid,
  output logic                   resp_pass,
  output logic [15:0]            ctrl_status,
  output logic                   inhibit_active,
  output logic                   prod_mode_ok,
  output logic                   read_allowed
);
  fwil_pkg::fwil_regs_t r_q, r_d;
  logic rst_s1_q, rst_s2_q;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic lock_hit(input logic [23:0] a);
    lock_hit = (a == `FWIL_LOCK1_ADDR) || (a == `FWIL_LOCK2_ADDR);
  endfunction

  function automatic logic lock_value_ok(input logic [23:0] a,
                                         input logic [23:0] d);
    lock_value_ok = ((a == `FWIL_LOCK1_ADDR) &&
                     (d[15:0] == `FWIL_LOCK1_VALUE)) ||
                    ((a == `FWIL_LOCK2_ADDR) &&
                     (d[15:0] == `FWIL_LOCK2_VALUE));
  endfunction

  function automatic logic lock_programmed(input logic [23:0] a,
                                           input logic [15:0] w1,
                                           input logic [15:0] w2);
    lock_programmed = ((a == `FWIL_LOCK1_ADDR) && (w1 != `FWIL_ERASED_WORD))
                   || ((a == `FWIL_LOCK2_ADDR) && (w2 != `FWIL_ERASED_WORD));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset released through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic ext_src, lock_sel, port_block, lock_block, pass_d;
  always_comb begin
    r_d = r_q;
    r_d.grant = 1'b0;
    r_d.resp_valid = 1'b0;
    r_d.resp_pass = 1'b0;
    r_d.wr_bit = 1'b0;
    ext_src = (req_src != fwil_pkg::FWIL_SRC_SELF);
    lock_sel = lock_hit(req_addr);
    port_block = r_q.active && ext_src;
    // Lock words obey the same guard from every source
    lock_block = lock_sel &&
                 (lock_programmed(req_addr, lock1_word, lock2_word) ||
                  (req_op != fwil_pkg::FWIL_OP_WORD) ||
                  !lock_value_ok(req_addr, req_data));
    pass_d = (target_word == req_data[15:0]);
    unique case (r_q.state)
      fwil_pkg::FWIL_ST_RESET: r_d.state = fwil_pkg::FWIL_ST_LOAD;
      fwil_pkg::FWIL_ST_LOAD: begin
        // Sampled once; lock words change later only by arming
        r_d.active = (lock1_word == `FWIL_LOCK1_VALUE) &&
                     (lock2_word == `FWIL_LOCK2_VALUE);
        r_d.state = fwil_pkg::FWIL_ST_RUN;
      end
      fwil_pkg::FWIL_ST_RUN: begin
        if (prod_mode_req && !r_q.active) begin
          r_d.prod_ok = 1'b1;
        end
        if (r_q.active) begin
          r_d.prod_ok = 1'b0;
        end
        if (ctrl_wr_set && port_block) begin
          r_d.err_bit = 1'b1;
        end else if (ctrl_wr_set) begin
          r_d.wr_bit = 1'b1;
          r_d.err_bit = 1'b0;
        end
        if (req_valid) begin
          r_d.resp_valid = 1'b1;
          if (port_block || lock_block) begin
            // Checked programs pass only when nothing needs writing
            r_d.resp_pass = (req_op == fwil_pkg::FWIL_OP_CHECKED) &&
                            pass_d && !lock_sel;
          end else begin
            r_d.grant = 1'b1;
            r_d.resp_pass = 1'b1;
          end
        end
      end
      default: r_d.state = fwil_pkg::FWIL_ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      r_q <= '{state: fwil_pkg::FWIL_ST_RESET, default: 1'b0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign grant = r_q.grant;
  assign resp_valid = r_q.resp_valid;
  assign resp_pass = r_q.resp_pass;
  assign inhibit_active = r_q.active;
  assign prod_mode_ok = r_q.prod_ok;
  assign read_allowed = 1'b1;
  always_comb begin
    ctrl_status = 16'h0000;
    ctrl_status[`FWIL_CTRL_WR_BIT] = r_q.wr_bit;
    ctrl_status[`FWIL_CTRL_ERR_BIT] = r_q.err_bit;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks but a_prod_blocked, a_active_held and a_read_open qualify on clk_en: a frozen edge moves no state
  logic in_run;
  assign in_run = (r_q.state == fwil_pkg::FWIL_ST_RUN);

  a_no_ext_grant: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && r_q.active && ext_src && in_run |=> !grant)
    else $error("external write granted while inhibited");
  a_self_grant: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && !ext_src && !lock_sel && in_run
    |=> grant && resp_pass)
    else $error("self write not granted");
  a_wr_stays_low: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && ctrl_wr_set && port_block && in_run
    |=> !ctrl_status[`FWIL_CTRL_WR_BIT] && ctrl_status[`FWIL_CTRL_ERR_BIT])
    else $error("write start not turned into error");
  a_start_free: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && ctrl_wr_set && !r_q.active && in_run
    |=> ctrl_status[`FWIL_CTRL_WR_BIT] && !ctrl_status[`FWIL_CTRL_ERR_BIT])
    else $error("write start lost while not inhibited");
  a_err_held: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && !ctrl_wr_set && ctrl_status[`FWIL_CTRL_ERR_BIT]
    |=> ctrl_status[`FWIL_CTRL_ERR_BIT])
    else $error("write error flag dropped");
  a_checked_resp: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && port_block && !lock_sel && in_run &&
    req_op == fwil_pkg::FWIL_OP_CHECKED
    |=> resp_valid && !grant &&
        (resp_pass == $past(target_word == req_data[15:0])))
    else $error("checked response wrong");
  a_lock_checked: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && in_run && lock_sel &&
    req_op == fwil_pkg::FWIL_OP_CHECKED |=> !grant && !resp_pass)
    else $error("checked program of lock word passed");
  a_answer_next: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && in_run |=> resp_valid)
    else $error("request left without answer");
  a_prod_blocked: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    inhibit_active |-> ##1 !prod_mode_ok)
    else $error("production switch while inhibited");
  a_prod_free: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && prod_mode_req && !r_q.active && in_run |=> prod_mode_ok)
    else $error("production switch refused while open");
  a_debug_refused: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && in_run && r_q.active &&
    req_src == fwil_pkg::FWIL_SRC_DEBUG |=> resp_valid && !grant)
    else $error("debug write granted while inhibited");
  a_bad_value: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid &&
    ((req_addr == `FWIL_LOCK1_ADDR && req_data[15:0] != `FWIL_LOCK1_VALUE) ||
     (req_addr == `FWIL_LOCK2_ADDR && req_data[15:0] != `FWIL_LOCK2_VALUE))
    |=> !grant)
    else $error("wrong lock value accepted");
  a_load_value: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && r_q.state == fwil_pkg::FWIL_ST_LOAD
    |=> inhibit_active == ($past(lock1_word) == `FWIL_LOCK1_VALUE &&
                           $past(lock2_word) == `FWIL_LOCK2_VALUE))
    else $error("inhibit not taken from both lock words");
  a_lock_guard: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && lock_block |=> !grant)
    else $error("lock location overwritten");
  a_lock_once: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid &&
    ((req_addr == `FWIL_LOCK1_ADDR && lock1_word != `FWIL_ERASED_WORD) ||
     (req_addr == `FWIL_LOCK2_ADDR && lock2_word != `FWIL_ERASED_WORD))
    |=> !grant)
    else $error("programmed lock word accepted again");
  a_quiet_idle: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && !(req_valid && in_run) |=> !grant && !resp_valid)
    else $error("grant without a request");
  a_arm_accept: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && in_run && !r_q.active &&
    req_op == fwil_pkg::FWIL_OP_WORD && req_addr == `FWIL_LOCK1_ADDR &&
    lock1_word == `FWIL_ERASED_WORD && req_data[15:0] == `FWIL_LOCK1_VALUE
    |=> grant)
    else $error("first lock word refused");
  a_row_refused: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    clk_en && req_valid && req_op != fwil_pkg::FWIL_OP_WORD &&
    (req_addr == `FWIL_LOCK1_ADDR || req_addr == `FWIL_LOCK2_ADDR)
    |=> !grant)
    else $error("lock word written by other than word program");
  a_active_held: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    in_run |=> $stable(inhibit_active))
    else $error("inhibit changed between resets");
  a_read_open: assert property (
    @(posedge core_clk) disable iff (!rst_s2_q)
    inhibit_active |-> read_allowed)
    else $error("reads blocked");
endmodule

// ---- tb/fwil_nvm_model.sv ----
// Model of the nonvolatile cells holding both lock words
`include "fwil_params.svh"
module fwil_nvm_model (
  input  wire logic        core_clk,
  input  wire logic        req_valid,
  input  wire logic [23:0] req_addr,
  input  wire logic [23:0] req_data,
  input  wire logic        grant,
  output logic      [15:0] lock1_word,
  output logic      [15:0] lock2_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] addr_q;
  logic [23:0] data_q;
  // Cells survive resets, so only time zero erases them
  initial begin
    lock1_word = `FWIL_ERASED_WORD;
    lock2_word = `FWIL_ERASED_WORD;
  end
  always @(posedge core_clk) begin
    if (req_valid) begin
      addr_q <= req_addr;
      data_q <= req_data;
    end
    if (grant && addr_q == `FWIL_LOCK1_ADDR) lock1_word <= data_q[15:0];
    if (grant && addr_q == `FWIL_LOCK2_ADDR) lock2_word <= data_q[15:0];
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the flash write inhibit lock
`include "fwil_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, resetn = 0, req_valid = 0;
  logic        ctrl_wr_set = 0, prod_mode_req = 0, clk_en = 1;
  fwil_pkg::fwil_src_t req_src = fwil_pkg::FWIL_SRC_PORT;
  fwil_pkg::fwil_op_t  req_op = fwil_pkg::FWIL_OP_WORD;
  logic [23:0] req_addr = 24'h0, req_data = 24'h0;
  logic [15:0] target_word = 16'h0, lock1_word, lock2_word, ctrl_status;
  logic        grant, resp_valid, resp_pass, inhibit_active;
  logic        prod_mode_ok, read_allowed;
  int          n_mismatch = 0, n_compared = 0, cycles = 0;
  localparam logic [23:0] V1 = {8'h00, `FWIL_LOCK1_VALUE};
  localparam logic [23:0] V2 = {8'h00, `FWIL_LOCK2_VALUE};
  always #25 core_clk = ~core_clk;
  fwil_lock i_fwil_lock (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .lock1_word(lock1_word), .lock2_word(lock2_word), .req_valid(req_valid),
    .req_src(req_src), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .target_word(target_word), .ctrl_wr_set(ctrl_wr_set),
    .prod_mode_req(prod_mode_req), .grant(grant), .resp_valid(resp_valid),
    .resp_pass(resp_pass), .ctrl_status(ctrl_status),
    .inhibit_active(inhibit_active), .prod_mode_ok(prod_mode_ok),
    .read_allowed(read_allowed));
  fwil_nvm_model i_fwil_nvm_model (.core_clk(core_clk), .req_valid(req_valid),
    .req_addr(req_addr), .req_data(req_data), .grant(grant),
    .lock1_word(lock1_word), .lock2_word(lock2_word));
  task automatic chk(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One request, answer judged half a cycle after it is taken
  task automatic req(input logic [1:0] s, o, input logic [23:0] a, d,
                     input logic [15:0] tw, input logic eg, ep);
    @(negedge core_clk);
    req_src = fwil_pkg::fwil_src_t'(s);
    req_op = fwil_pkg::fwil_op_t'(o);
    req_addr = a;
    req_data = d;
    target_word = tw;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    chk({14'h0, resp_valid, grant}, {14'h0, 1'b1, eg}, "answer");
    if (o == 2'd3) chk({15'h0, resp_pass}, {15'h0, ep}, "pass");
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic t_bad_arming();
    req(2'd0, 2'd0, `FWIL_LOCK1_ADDR, V1 ^ 24'h1, 16'h0, 0, 0);
    req(2'd0, 2'd1, `FWIL_LOCK1_ADDR, V1, 16'h0, 0, 0);
    req(2'd0, 2'd0, `FWIL_LOCK2_ADDR, V1, 16'h0, 0, 0);
    req(2'd0, 2'd0, 24'h000100, 24'h1234, 16'h0, 1, 0);
    @(negedge core_clk);
    req_src = fwil_pkg::FWIL_SRC_PORT;
    ctrl_wr_set = 1'b1;
    prod_mode_req = 1'b1;
    @(negedge core_clk);
    ctrl_wr_set = 1'b0;
    prod_mode_req = 1'b0;
    chk({14'h0, ctrl_status[15], ctrl_status[13]}, 16'h2, "start");
    chk({15'h0, prod_mode_ok}, 16'h1, "production free");
  endtask
  task automatic t_arm();
    req(2'd2, 2'd0, `FWIL_LOCK2_ADDR, V2, 16'h0, 1, 0);
    req(2'd2, 2'd2, `FWIL_LOCK2_ADDR, 24'h0, 16'h0, 0, 0);
    do_reset();
    chk({15'h0, inhibit_active}, 16'h0, "half armed");
    req(2'd1, 2'd0, `FWIL_LOCK1_ADDR, V1, 16'h0, 1, 0);
    req(2'd2, 2'd0, `FWIL_LOCK1_ADDR, V1, 16'h0, 0, 0);
    chk(lock1_word, `FWIL_LOCK1_VALUE, "lock one");
    chk({15'h0, inhibit_active}, 16'h0, "before reset");
  endtask
  task automatic t_active();
    do_reset();
    chk({15'h0, inhibit_active}, 16'h1, "active");
    req(2'd0, 2'd0, 24'h000200, 24'h5, 16'h0, 0, 0);
    req(2'd0, 2'd2, 24'h000200, 24'h0, 16'h0, 0, 0);
    req(2'd2, 2'd0, 24'h000200, 24'h5, 16'h0, 1, 0);
    req(2'd2, 2'd2, 24'h000200, 24'h0, 16'h0, 1, 0);
    req(2'd1, 2'd3, 24'h000300, 24'h77, 16'h0077, 0, 1);
    req(2'd1, 2'd3, 24'h000300, 24'h77, 16'h0076, 0, 0);
    req(2'd3, 2'd2, 24'h000300, 24'h0, 16'h0, 0, 0);
    chk({15'h0, read_allowed}, 16'h1, "read");
    @(negedge core_clk);
    req_src = fwil_pkg::FWIL_SRC_PORT;
    ctrl_wr_set = 1'b1;
    prod_mode_req = 1'b1;
    @(negedge core_clk);
    ctrl_wr_set = 1'b0;
    chk({14'h0, ctrl_status[15], ctrl_status[13]}, 16'h1, "status");
    repeat (3) @(negedge core_clk);
    chk({15'h0, prod_mode_ok}, 16'h0, "production");
    chk({15'h0, ctrl_status[13]}, 16'h1, "error held");
    prod_mode_req = 1'b0;
  endtask
  // A request on a frozen edge must leave no answer behind
  task automatic t_freeze();
    @(negedge core_clk);
    clk_en = 1'b0;
    req_src = fwil_pkg::FWIL_SRC_SELF;
    req_op = fwil_pkg::FWIL_OP_WORD;
    req_addr = 24'h000400;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    chk({14'h0, resp_valid, grant}, 16'h0, "frozen");
    clk_en = 1'b1;
    chk({15'h0, inhibit_active}, 16'h1, "held");
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Whole run is about 120 cycles; a hang ends at cycle 2000, well above it
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    t_bad_arming();
    t_arm();
    t_active();
    t_freeze();
    give_verdict();
  end
endmodule
